// >>> hdl/sad_map.vh
// system address decoder constants: region bases, sizes, peripheral ids
// assumes 32-bit byte addresses from the bus masters
`ifndef SAD_MAP_VH
`define SAD_MAP_VH
`define SAD_CODE_RAM_BASE   32'h00800000
`define SAD_DATA_RAM_BASE   32'h20000000
`define SAD_RAM_BYTES       32'h00008000
`define SAD_FLASH_BASE      32'h00000000
`define SAD_FLASH_BYTES     32'h00040000
`define SAD_FACTORY_BASE    32'h10000000
`define SAD_USER_CFG_BASE   32'h10001000
`define SAD_WIN_BYTES       32'h00001000
`define SAD_PERIPH_BASE     32'h40000000
`define SAD_HS_PERIPH_BASE  32'h50000000
`define SAD_PERIPH_SPAN     32'h00040000
`define SAD_RAM_SLAVES      4
`define SAD_SECTIONS        8
`define SAD_FLASH_WAIT      2'h2
`define SAD_ID_SERIAL_PORT  6'h02
`define SAD_ID_SERIAL_SHARE 6'h03
`define SAD_ID_CIPHER_BLK   6'h0e
`define SAD_ID_CIPHER_AUTH  6'h0f
`define SAD_ID_BUS_DEVICE   6'h27
`endif

// >>> hdl/sad_decoder.v
// system address decoder: maps one master access to flash, ram, config or peripherals
// assumes one access offered at a time, held until ready; inputs synchronous to clk
`timescale 1ns/1ps
`include "sad_map.vh"
module sad_decoder (
  // clock and reset
  input  wire        clk,
  input  wire        arst_n,
  // master request
  input  wire        req_valid,
  input  wire [31:0] req_addr,
  input  wire        req_write,
  input  wire [1:0]  req_size,
  input  wire        req_ifetch,
  // flash controller state and section power settings
  input  wire        flash_busy,
  input  wire [7:0]  sect_on_pwr,
  input  wire [7:0]  sect_off_pwr,
  input  wire        system_off,
  // answer
  output reg         resp_ready,
  output reg         resp_error,
  output reg         hard_fault,
  // selects pulse one cycle with resp_ready; offset, page, ifetch and id hold, sect_power is reloaded every cycle
  output reg  [3:0]  ram_slave_sel,
  output reg  [12:0] ram_offset,
  output reg         flash_sel,
  output reg  [5:0]  flash_page,
  output reg         flash_on_ifetch,
  output reg         factory_sel,
  output reg         user_cfg_sel,
  output reg         periph_sel,
  output reg  [5:0]  periph_id,
  output reg         pin_port_sel,
  output reg  [7:0]  sect_power
);
  localparam ST_IDLE  = 2'b01;
  localparam ST_FLASH = 2'b10;
  reg  [1:0]  state;
  reg  [1:0]  wait_cnt;
  reg         hold_ifetch;
  reg  [5:0]  hold_page;
  // next value of every flop except sect_power, worked out in one combinational process
  reg  [1:0]  next_state;
  reg  [1:0]  next_wait_cnt;
  reg         next_hold_ifetch;
  reg  [5:0]  next_hold_page;
  reg         next_resp_ready;
  reg         next_resp_error;
  reg         next_hard_fault;
  reg  [3:0]  next_ram_slave_sel;
  reg  [12:0] next_ram_offset;
  reg         next_flash_sel;
  reg  [5:0]  next_flash_page;
  reg         next_flash_on_ifetch;
  reg         next_factory_sel;
  reg         next_user_cfg_sel;
  reg         next_periph_sel;
  reg  [5:0]  next_periph_id;
  reg         next_pin_port_sel;
  localparam [31:0] FAC_BASE = `SAD_FACTORY_BASE;
  localparam [31:0] CFG_BASE = `SAD_USER_CFG_BASE;
  localparam [31:0] PIN_BASE = `SAD_HS_PERIPH_BASE;
  wire [31:0] code_off = req_addr - `SAD_CODE_RAM_BASE;
  wire [31:0] data_off = req_addr - `SAD_DATA_RAM_BASE;
  wire [31:0] per_off  = req_addr - `SAD_PERIPH_BASE;
  wire        hit_code = req_addr >= `SAD_CODE_RAM_BASE && code_off < `SAD_RAM_BYTES;
  wire        hit_data = req_addr >= `SAD_DATA_RAM_BASE && data_off < `SAD_RAM_BYTES;
  // both aliases collapse onto one physical offset
  wire [14:0] ram_off  = hit_code ? code_off[14:0] : data_off[14:0];
  wire        hit_ram  = hit_code | hit_data;
  wire        hit_fl   = req_addr < `SAD_FLASH_BYTES;
  wire        hit_fac  = req_addr[31:12] == FAC_BASE[31:12];
  wire        hit_ucfg = req_addr[31:12] == CFG_BASE[31:12];
  wire        hit_per  = req_addr >= `SAD_PERIPH_BASE && per_off < `SAD_PERIPH_SPAN;
  wire        hit_pin  = req_addr[31:12] == PIN_BASE[31:12];
  // each id owns base + id*0x1000; shared ids each land on their own base
  wire [5:0]  pid      = per_off[17:12];
  wire        narrow   = req_size != 2'h2 || req_addr[1:0] != 2'h0;
  wire [7:0]  pwr;
  genvar g;
  generate
    for (g = 0; g < `SAD_SECTIONS; g = g + 1) begin : g_pwr
      assign pwr[g] = system_off ? sect_off_pwr[g] : sect_on_pwr[g];
    end
  endgenerate
  always @* begin
    // pulses default low, held fields keep their value
    next_state           = state;
    next_wait_cnt        = wait_cnt;
    next_hold_ifetch     = hold_ifetch;
    next_hold_page       = hold_page;
    next_resp_ready      = 1'b0;
    next_resp_error      = 1'b0;
    next_hard_fault      = 1'b0;
    next_ram_slave_sel   = 4'h0;
    next_ram_offset      = ram_offset;
    next_flash_sel       = 1'b0;
    next_flash_page      = flash_page;
    next_flash_on_ifetch = flash_on_ifetch;
    next_factory_sel     = 1'b0;
    next_user_cfg_sel    = 1'b0;
    next_periph_sel      = 1'b0;
    next_periph_id       = periph_id;
    next_pin_port_sel    = 1'b0;
    case (state)
      ST_IDLE: begin
        if (req_valid && !resp_ready) begin
          if (hit_ram) begin
            // slave index = two sections of 4 kB each
            next_ram_slave_sel = 4'h1 << ram_off[14:13];
            next_ram_offset    = ram_off[12:0];
            next_resp_ready    = 1'b1;
          end else if (hit_fl) begin
            if (req_write) begin
              // writes never program the array on this path
              next_resp_ready = 1'b1;
              next_hard_fault = narrow;
              next_resp_error = narrow;
            end else begin
              next_state       = ST_FLASH;
              next_wait_cnt    = 2'h0;
              next_hold_page   = req_addr[17:12];
              next_hold_ifetch = req_ifetch;
            end
          end else if (hit_fac || hit_ucfg) begin
            next_factory_sel  = hit_fac;
            next_user_cfg_sel = hit_ucfg;
            next_resp_ready   = 1'b1;
          end else if (hit_per) begin
            next_periph_sel = 1'b1;
            next_periph_id  = pid;
            next_resp_ready = 1'b1;
          end else if (hit_pin) begin
            next_pin_port_sel = 1'b1;
            next_resp_ready   = 1'b1;
          end else begin
            next_resp_ready = 1'b1;
            next_resp_error = 1'b1;
          end
        end
      end
      ST_FLASH: begin
        // wait counter frozen while controller busy, so stall has no bound here
        if (!flash_busy) begin
          if (wait_cnt == `SAD_FLASH_WAIT - 2'h1) begin
            next_state           = ST_IDLE;
            next_flash_sel       = 1'b1;
            next_flash_page      = hold_page;
            next_flash_on_ifetch = hold_ifetch;
            next_resp_ready      = 1'b1;
          end else begin
            next_wait_cnt = wait_cnt + 2'h1;
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end
  // every output leaves a flop; decode above only feeds next values
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state           <= ST_IDLE;
      wait_cnt        <= 2'h0;
      hold_ifetch     <= 1'b0;
      hold_page       <= 6'h0;
      resp_ready      <= 1'b0;
      resp_error      <= 1'b0;
      hard_fault      <= 1'b0;
      ram_slave_sel   <= 4'h0;
      ram_offset      <= 13'h0;
      flash_sel       <= 1'b0;
      flash_page      <= 6'h0;
      flash_on_ifetch <= 1'b0;
      factory_sel     <= 1'b0;
      user_cfg_sel    <= 1'b0;
      periph_sel      <= 1'b0;
      periph_id       <= 6'h0;
      pin_port_sel    <= 1'b0;
      sect_power      <= 8'h0;
    end else begin
      state           <= next_state;
      wait_cnt        <= next_wait_cnt;
      hold_ifetch     <= next_hold_ifetch;
      hold_page       <= next_hold_page;
      resp_ready      <= next_resp_ready;
      resp_error      <= next_resp_error;
      hard_fault      <= next_hard_fault;
      ram_slave_sel   <= next_ram_slave_sel;
      ram_offset      <= next_ram_offset;
      flash_sel       <= next_flash_sel;
      flash_page      <= next_flash_page;
      flash_on_ifetch <= next_flash_on_ifetch;
      factory_sel     <= next_factory_sel;
      user_cfg_sel    <= next_user_cfg_sel;
      periph_sel      <= next_periph_sel;
      periph_id       <= next_periph_id;
      pin_port_sel    <= next_pin_port_sel;
      sect_power      <= pwr;
    end
  end
endmodule

// >>> tb/sad_checker.sv
// checker: decoder answer timing and select decode
// bound to sad_decoder, sees only its ports
`timescale 1ns/1ps
module sad_checker (
  input wire        clk, arst_n, req_valid, req_write, flash_busy,
  input wire [31:0] req_addr,
  input wire [1:0]  req_size,
  input wire        resp_ready, resp_error, hard_fault, periph_sel, pin_port_sel,
  input wire [3:0]  ram_slave_sel,
  input wire [5:0]  periph_id
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  wire ram = req_addr[31:15] == 17'h100 || req_addr[31:15] == 17'h4000;
  wire fl = req_addr[31:18] == 14'h0;
  AST_RAM: assert property ($rose(req_valid) && ram |=> resp_ready && ram_slave_sel == 4'h1 << req_addr[14:13])
    else $error("ram answer late or wrong slave");
  AST_FL_RD: assert property (($rose(req_valid) && fl && !req_write && !flash_busy) ##1 (!flash_busy)[*2]
    |=> resp_ready)
    else $error("flash read over two waits");
  AST_STALL: assert property ((req_valid && fl && !req_write && flash_busy)[*3] |=> !resp_ready)
    else $error("flash answered while busy");
  AST_NARROW: assert property ($rose(req_valid) && fl && req_write && (req_size != 2'h2 || req_addr[1:0] != 2'h0)
    |=> resp_error && hard_fault)
    else $error("narrow flash write not faulted");
  AST_WORD: assert property ($rose(req_valid) && fl && req_write && req_size == 2'h2 && req_addr[1:0] == 2'h0
    |=> resp_ready && !resp_error)
    else $error("word flash write refused");
  AST_UNMAP: assert property ($rose(req_valid) && req_addr[31:29] == 3'h3 |=> resp_ready && resp_error)
    else $error("unmapped access without error");
  AST_PERIPH: assert property ($rose(req_valid) && req_addr[31:18] == 14'h1000
    |=> periph_sel && periph_id == req_addr[17:12])
    else $error("peripheral window wrong");
  AST_PIN: assert property ($rose(req_valid) && req_addr[31:12] == 20'h50000 |=> pin_port_sel && !periph_sel)
    else $error("pin port not selected");
endmodule
bind sad_decoder sad_checker u_chk (.*);

// >>> tb/sad_master_model.sv
// master model: one request, held until answered
// assumes an answer within 50 cycles
`timescale 1ns/1ps
module sad_master_model (
  input  wire        clk,
  input  wire        resp_ready,
  output reg         req_valid,
  output reg  [31:0] req_addr,
  output reg         req_write,
  output reg  [1:0]  req_size,
  output reg         req_ifetch
);
  initial {req_valid, req_addr, req_write, req_size, req_ifetch} = 37'h0;
  task access(input [31:0] a, input w, input [1:0] s, input i, output int n);
    begin
      @(posedge clk);
      {req_valid, req_addr, req_write, req_size, req_ifetch} <= {1'b1, a, w, s, i};
      n = 0;
      do begin @(posedge clk); n++; end while (resp_ready !== 1'b1 && n < 50);
      req_valid <= 1'b0;
      req_addr <= ~a; // no stale address once released
    end
  endtask
endmodule

// >>> tb/tb_top.sv
// bench: random and corner accesses through the master model
// assumes decoder and master model compiled alongside
`timescale 1ns/1ps
module tb_top;
  reg clk, arst_n, flash_busy, system_off;
  reg [7:0] sect_on_pwr, sect_off_pwr, e;
  reg [31:0] lfsr = 32'ha2d54721, o, p;
  int errors = 0, compares = 0, n;
  int ids[5] = '{2, 3, 14, 15, 39};
  wire req_valid, req_write, req_ifetch, resp_ready, resp_error, hard_fault, flash_sel, flash_on_ifetch;
  wire factory_sel, user_cfg_sel, periph_sel, pin_port_sel;
  wire [31:0] req_addr;
  wire [1:0] req_size;
  wire [3:0] ram_slave_sel;
  wire [12:0] ram_offset;
  wire [5:0] flash_page, periph_id;
  wire [7:0] sect_power;
  reg [10:0] snap;
  sad_decoder u_dut (.*);
  sad_master_model u_mst (.*);
  function [31:0] rnd;
    begin lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]}; rnd = lfsr; end
  endfunction
  task chk(input [31:0] got, exp);
    begin
      compares++;
      if (got !== exp) begin errors++; $display("BAD %0t got %h want %h", $time, got, exp); end
    end
  endtask
  task go(input [31:0] a, input w, input [1:0] s);
    begin
      u_mst.access(a, w, s, lfsr[3], n);
      #1;
      if (n >= 50) begin errors++; $display("BAD %0t no answer", $time); end
    end
  endtask
  task print_verdict;
    begin
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  // selects are pulses: latch them with the answer
  always @(posedge clk) if (resp_ready) snap <= {resp_error, hard_fault, flash_sel, factory_sel,
    user_cfg_sel, periph_sel, pin_port_sel, ram_slave_sel};
  always @(posedge clk) {system_off, sect_off_pwr, sect_on_pwr} <= lfsr[16:0];
  initial begin clk = 0; forever #5 clk = ~clk; end
  initial begin #200000; errors++; print_verdict; end
  initial begin
    arst_n = 0; flash_busy = 0;
    repeat (10) @(posedge clk);
    arst_n <= 1;
    for (int k = 0; k < 12; k++) begin
      o = rnd() & 32'h7ffc;
      go(32'h00800000 | o, 1'b0, 2'h2);
      chk(n, 2);
      chk(snap, 11'h1 << o[14:13]);
      chk(ram_offset, o[12:0]);
      go(32'h20000000 | o, 1'b1, 2'h0);
      chk(ram_offset, o[12:0]);
      chk(snap, 11'h1 << o[14:13]);
      o = rnd() & 32'h3fffc;
      go(o, 1'b0, 2'h2);
      chk(n, 4);
      chk(flash_page, o[17:12]);
      chk(flash_on_ifetch, lfsr[3]);
      go(o, 1'b1, 2'h2);
      chk(snap[10:9], 0);
      go(o, 1'b1, {1'b0, k[0]});
      chk(snap[10:9], 3);
      p = k < 5 ? ids[k] : rnd();
      go(32'h40000000 | p[5:0] << 12, 1'b0, 2'h2);
      chk(periph_id, p[5:0]);
      chk(snap, 11'h20);
      e = system_off ? sect_off_pwr : sect_on_pwr;
      @(posedge clk);
      #1;
      chk(sect_power, e);
    end
    go(32'h50000000, 1'b0, 2'h2);
    chk(snap, 11'h10);
    go(32'h10000000, 1'b0, 2'h2);
    chk(snap, 11'h80);
    go(32'h10001000, 1'b1, 2'h2);
    chk(snap, 11'h40);
    go(32'h60000000, 1'b0, 2'h2);
    chk(snap, 11'h400);
    go(32'h00808000, 1'b0, 2'h2);
    chk(snap, 11'h400);
    go(32'h40040000, 1'b0, 2'h2);
    chk(snap, 11'h400);
    go(32'h40027000, 1'b0, 2'h2);
    chk(periph_id, 39);
    go(32'h4000e000, 1'b0, 2'h2);
    chk(periph_id, 14);
    go(32'h4000f000, 1'b1, 2'h2);
    chk(periph_id, 15);
    go(32'h00000102, 1'b1, 2'h2);
    chk(snap[10:9], 3);
    @(posedge clk);
    flash_busy <= 1'b1;
    fork
      go(32'h1000, 1'b0, 2'h2);
      begin repeat (5) @(posedge clk); flash_busy <= 1'b0; end
    join
    chk(n > 4, 1);
    chk(n < 9, 1);
    print_verdict;
  end
endmodule
